// File: logic/i2cac_top.v
// i2cac_top.v: serial-bus slave, control register, channel selection and
// successive-approximation sequencer of the converter front end.
// assumes scl/sda/strap pins are asynchronous and sampled by core_clk_i;
// the analog comparator result arrives on cmp_i, also asynchronous.
// Functional notes
// - answer only when fixed nibble and three strap pins match
// - address byte lsb selects read or write direction
// - first byte after a write address goes into control register
// - upper control nibble enables output and sets input configuration
// - lower control nibble picks the input channel
// - auto-increment advances channel after every conversion
// - nonexistent channel maps to highest available channel
// - auto-increment wraps to channel 0 after the highest
// - reset clears every control bit
// - after reset dac and oscillator off, analog output high impedance
// - four inputs grouped by programmable configuration
// - 8-bit result by successive approximation per conversion
// - third and later written bytes go into dac data register
// - read ack trailing edge starts conversion; previous result is sent
// - first read byte after reset is 80 hex
// - write ends on stop or on a new start
`timescale 1ns/1ps
`include "i2cac_consts.vh"
module i2cac_top #(
  parameter [3:0] FIXED_ADDR = 4'h5,
  parameter [7:0] SAR_STEP_CYC = `I2CAC_SAR_STEP_CYC
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_n_o,
  input wire addr_strap_bit0_i,
  input wire addr_strap_bit1_i,
  input wire addr_strap_bit2_i,
  input wire cmp_i,
  output reg [7:0] ctrl_o,
  output reg [1:0] chan_sel_o,
  output reg [1:0] input_mode_o,
  output reg [7:0] dac_code_o,
  output reg dac_enable_o,
  output reg analog_output_pin_hiz_o,
  output reg osc_enable_o,
  output reg track_hold_o,
  output reg [7:0] adc_result_o
);
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_ACKA = 7'h04;
  localparam [6:0] ST_WR = 7'h08;
  localparam [6:0] ST_ACKW = 7'h10;
  localparam [6:0] ST_RD = 7'h20;
  localparam [6:0] ST_ACKR = 7'h40;

  // highest channel that exists in each input configuration
  function [1:0] max_ch;
    input [1:0] mode;
    begin
      case (mode)
        `I2CAC_MODE_4SE: max_ch = 2'd3;
        `I2CAC_MODE_3DIFF: max_ch = 2'd2;
        `I2CAC_MODE_MIXED: max_ch = 2'd2;
        default: max_ch = 2'd1;
      endcase
    end
  endfunction

  function [1:0] eff_ch;
    input [1:0] mode;
    input [1:0] ch;
    begin
      eff_ch = (ch > max_ch(mode)) ? max_ch(mode) : ch;
    end
  endfunction

  wire [5:0] sync_w;
  wire scl_s;
  wire sda_s;
  wire [2:0] strap_s;
  wire cmp_s;
  assign {cmp_s, strap_s, sda_s, scl_s} = sync_w;

  i2cac_sync #(.W(6), .RST_VAL(6'h03)) u_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i({cmp_i, addr_strap_bit2_i, addr_strap_bit1_i,
              addr_strap_bit0_i, sda_i, scl_i}),
    .sync_o(sync_w)
  );

  reg scl_d_r;
  reg sda_d_r;
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;

  reg [6:0] state_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] rx_r;
  reg byte_done_r;
  reg [7:0] tx_r;
  reg wr_first_r;
  reg mack_r;
  reg [7:0] ctrl_r;
  reg [7:0] dac_r;
  reg [7:0] result_r;
  reg conv_go;

  // sar sequencer
  reg busy_r;
  reg [7:0] trial_r;
  reg [7:0] bitmask_r;
  reg [7:0] step_cnt_r;

  wire [7:0] rx_full = {rx_r[6:0], sda_s};
  wire addr_hit = (rx_r[`I2CAC_ADDR_FIX_HI:`I2CAC_ADDR_FIX_LO] ==
                   FIXED_ADDR) &&
                  (rx_r[`I2CAC_ADDR_STRAP_HI:`I2CAC_ADDR_STRAP_LO] ==
                   strap_s);
  wire [1:0] mode_w = ctrl_r[`I2CAC_CTRL_MODE_HI:`I2CAC_CTRL_MODE_LO];
  wire [1:0] ch_raw = ctrl_r[`I2CAC_CTRL_CH_HI:`I2CAC_CTRL_CH_LO];
  wire [1:0] ch_w = eff_ch(mode_w, ch_raw);
  wire step_end = busy_r && (step_cnt_r == SAR_STEP_CYC - 8'd1);
  wire conv_end = step_end && bitmask_r[0];

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'd0;
      rx_r <= 8'h00;
      byte_done_r <= 1'b0;
      tx_r <= 8'h00;
      wr_first_r <= 1'b0;
      mack_r <= 1'b0;
      ctrl_r <= `I2CAC_CTRL_RST;
      dac_r <= `I2CAC_DAC_RST;
      sda_oe_n_o <= 1'b1;
      conv_go <= 1'b0;
    end else begin
      conv_go <= 1'b0;
      if (conv_end && ctrl_r[`I2CAC_CTRL_AINC_BIT]) begin
        ctrl_r[`I2CAC_CTRL_CH_HI:`I2CAC_CTRL_CH_LO] <=
          (ch_w == max_ch(mode_w)) ? 2'd0 : ch_w + 2'd1;
      end
      if (start_ev) begin
        // new start aborts anything, address byte follows
        state_r <= ST_ADDR;
        bit_cnt_r <= 3'd0;
        byte_done_r <= 1'b0;
        sda_oe_n_o <= 1'b1;
      end else if (stop_ev) begin
        state_r <= ST_IDLE;
        sda_oe_n_o <= 1'b1;
      end else begin
        case (state_r)
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              rx_r <= rx_full;
              bit_cnt_r <= bit_cnt_r + 3'd1;
              byte_done_r <= (bit_cnt_r == 3'd7);
            end else if (scl_fall && byte_done_r) begin
              byte_done_r <= 1'b0;
              if (state_r == ST_ADDR) begin
                if (addr_hit) begin
                  state_r <= ST_ACKA;
                  sda_oe_n_o <= 1'b0;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else begin
                state_r <= ST_ACKW;
                sda_oe_n_o <= 1'b0;
                wr_first_r <= 1'b0;
                if (wr_first_r)
                  ctrl_r <= rx_r;
                else
                  dac_r <= rx_r;
              end
            end
          end
          ST_ACKA: begin
            if (scl_fall) begin
              bit_cnt_r <= 3'd0;
              if (rx_r[`I2CAC_ADDR_RW_BIT]) begin
                // previous result goes out while new one converts
                state_r <= ST_RD;
                tx_r <= {result_r[6:0], 1'b0};
                sda_oe_n_o <= result_r[7];
                conv_go <= 1'b1;
              end else begin
                state_r <= ST_WR;
                wr_first_r <= 1'b1;
                sda_oe_n_o <= 1'b1;
              end
            end
          end
          ST_ACKW: begin
            if (scl_fall) begin
              state_r <= ST_WR;
              bit_cnt_r <= 3'd0;
              sda_oe_n_o <= 1'b1;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              bit_cnt_r <= bit_cnt_r + 3'd1;
              if (bit_cnt_r == 3'd7) begin
                state_r <= ST_ACKR;
                sda_oe_n_o <= 1'b1;
              end else begin
                sda_oe_n_o <= tx_r[7];
                tx_r <= {tx_r[6:0], 1'b0};
              end
            end
          end
          ST_ACKR: begin
            if (scl_rise)
              mack_r <= ~sda_s;
            else if (scl_fall) begin
              bit_cnt_r <= 3'd0;
              if (mack_r) begin
                state_r <= ST_RD;
                tx_r <= {result_r[6:0], 1'b0};
                sda_oe_n_o <= result_r[7];
                conv_go <= 1'b1;
              end else begin
                // master nack: leave the line high for its stop
                state_r <= ST_IDLE;
              end
            end
          end
          ST_IDLE: state_r <= ST_IDLE;
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // 8-step successive approximation on the shared dac; a new read ack
  // restarts an unfinished conversion, losing it, since bus speed
  // sets the rate; the compare result trails a new trial code by five
  // cycles through the synchroniser, so steps below six cycles go stale
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      busy_r <= 1'b0;
      trial_r <= 8'h00;
      bitmask_r <= 8'h00;
      step_cnt_r <= 8'd0;
      result_r <= `I2CAC_ADC_RST;
    end else if (conv_go) begin
      busy_r <= 1'b1;
      trial_r <= `I2CAC_SAR_MSB;
      bitmask_r <= `I2CAC_SAR_MSB;
      step_cnt_r <= 8'd0;
    end else if (busy_r) begin
      if (step_end) begin
        step_cnt_r <= 8'd0;
        bitmask_r <= bitmask_r >> 1;
        if (conv_end) begin
          busy_r <= 1'b0;
          result_r <= cmp_s ? trial_r : (trial_r & ~bitmask_r);
        end else begin
          trial_r <= (cmp_s ? trial_r : (trial_r & ~bitmask_r)) |
                     (bitmask_r >> 1);
        end
      end else begin
        step_cnt_r <= step_cnt_r + 8'd1;
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      sda_o <= 1'b0;
      ctrl_o <= `I2CAC_CTRL_RST;
      chan_sel_o <= 2'd0;
      input_mode_o <= `I2CAC_MODE_4SE;
      dac_code_o <= `I2CAC_DAC_RST;
      dac_enable_o <= 1'b0;
      analog_output_pin_hiz_o <= 1'b1;
      osc_enable_o <= 1'b0;
      track_hold_o <= 1'b0;
      adc_result_o <= `I2CAC_ADC_RST;
    end else begin
      sda_o <= 1'b0;
      ctrl_o <= ctrl_r;
      chan_sel_o <= ch_w;
      input_mode_o <= mode_w;
      dac_code_o <= busy_r ? trial_r : dac_r;
      dac_enable_o <= ctrl_r[`I2CAC_CTRL_AOE_BIT];
      analog_output_pin_hiz_o <= ~ctrl_r[`I2CAC_CTRL_AOE_BIT];
      // oscillator runs while output enabled or converting
      osc_enable_o <= ctrl_r[`I2CAC_CTRL_AOE_BIT] | busy_r;
      track_hold_o <= busy_r;
      adc_result_o <= result_r;
    end
  end
endmodule // i2cac_top

// File: pkg/i2cac_consts.vh
// i2cac_consts.vh: offsets, field positions, reset values and timing
// counts for the converter control front end.
// assumes a 40 MHz core clock; included by bare name.
`ifndef I2CAC_CONSTS_VH
`define I2CAC_CONSTS_VH

// control register fields
`define I2CAC_CTRL_RST 8'h00
`define I2CAC_CTRL_AOE_BIT 6
`define I2CAC_CTRL_RSV_HI_BIT 7
`define I2CAC_CTRL_MODE_HI 5
`define I2CAC_CTRL_MODE_LO 4
`define I2CAC_CTRL_RSV_LO_BIT 3
`define I2CAC_CTRL_AINC_BIT 2
`define I2CAC_CTRL_CH_HI 1
`define I2CAC_CTRL_CH_LO 0

// input configurations
`define I2CAC_MODE_4SE 2'h0
`define I2CAC_MODE_3DIFF 2'h1
`define I2CAC_MODE_MIXED 2'h2
`define I2CAC_MODE_2DIFF 2'h3

// data reset values
`define I2CAC_ADC_RST 8'h80
`define I2CAC_DAC_RST 8'h00
`define I2CAC_SAR_MSB 8'h80

// address layout: fixed nibble above three strap bits
`define I2CAC_ADDR_FIX_HI 7
`define I2CAC_ADDR_FIX_LO 4
`define I2CAC_ADDR_STRAP_HI 3
`define I2CAC_ADDR_STRAP_LO 1
`define I2CAC_ADDR_RW_BIT 0

// timing
`define I2CAC_CLK_PERIOD_NS 25
`define I2CAC_SAR_STEP_NS 200
// one sar step of 200 ns at 25 ns per core cycle
`define I2CAC_SAR_STEP_CYC 8'd8

`endif

// File: logic/i2cac_sync.v
// i2cac_sync.v: three-stage input synchroniser with agreement filter.
// assumes inputs are asynchronous to core_clk_i.
`timescale 1ns/1ps
module i2cac_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar g;

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // each bit moves only once stages two and three agree
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge core_clk_i) begin
        if (srst_i)
          sync_o[g] <= RST_VAL[g];
        else if (s2_r[g] == s3_r[g])
          sync_o[g] <= s3_r[g];
      end
    end
  endgenerate
endmodule // i2cac_sync

// File: tb/i2cac_props.sv
// i2cac_props.sv: port-level checks of the converter front end.
// assumes binding into i2cac_top with the same SAR_STEP_CYC.
`timescale 1ns/1ps
module i2cac_props #(
  parameter [7:0] SAR_STEP_CYC = 8'd8
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire [7:0] ctrl_o,
  input wire [1:0] chan_sel_o,
  input wire [1:0] input_mode_o,
  input wire dac_enable_o,
  input wire analog_output_pin_hiz_o,
  input wire osc_enable_o,
  input wire sda_oe_n_o,
  input wire track_hold_o,
  input wire [7:0] adc_result_o
);
  localparam int CONV_MAX = 8 * SAR_STEP_CYC + 4;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  function automatic [1:0] top_ch(input [1:0] m);
    top_ch = (m == 2'h0) ? 2'h3 : (m == 2'h3) ? 2'h1 : 2'h2;
  endfunction
  // registered outputs may trail the control copy by a cycle
  sequence s_settled;
    $stable(ctrl_o) [*2];
  endsequence
  sequence s_conv_end;
    ##[1:CONV_MAX] $fell(track_hold_o);
  endsequence
  a_reset_clears:
    assert property ($fell(srst_i) |-> ctrl_o == 8'h00 &&
      adc_result_o == 8'h80) else $error("reset values wrong");
  a_reset_quiet:
    assert property ($fell(srst_i) |-> analog_output_pin_hiz_o && !dac_enable_o &&
      !osc_enable_o && sda_oe_n_o) else $error("outputs live at reset");
  a_mode_field:
    assert property (s_settled |-> input_mode_o == ctrl_o[5:4])
      else $error("input mode differs from control");
  a_out_enable:
    assert property (s_settled |-> dac_enable_o == ctrl_o[6] &&
      analog_output_pin_hiz_o == !ctrl_o[6]) else $error("output enable wrong");
  a_chan_clamp:
    assert property (s_settled ##0 !track_hold_o |-> chan_sel_o ==
      ((ctrl_o[1:0] > top_ch(input_mode_o)) ? top_ch(input_mode_o) :
      ctrl_o[1:0])) else $error("channel select wrong");
  a_conv_bounded:
    assert property ($rose(track_hold_o) |-> s_conv_end)
      else $error("conversion too long");
  a_ainc_wrap:
    assert property ($fell(track_hold_o) && ctrl_o[2] &&
      $past(chan_sel_o, 2) == top_ch(input_mode_o) |->
      ##[0:4] chan_sel_o == 2'h0)
      else $error("channel did not wrap");
  a_no_ainc_hold:
    assert property ($fell(track_hold_o) && !ctrl_o[2] |=>
      $stable(ctrl_o) [*3]) else $error("channel moved without flag");
endmodule // i2cac_props
bind i2cac_top i2cac_props #(.SAR_STEP_CYC(SAR_STEP_CYC)) u_i2cac_props (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .ctrl_o(ctrl_o),
  .chan_sel_o(chan_sel_o), .input_mode_o(input_mode_o),
  .dac_enable_o(dac_enable_o), .analog_output_pin_hiz_o(analog_output_pin_hiz_o),
  .osc_enable_o(osc_enable_o), .sda_oe_n_o(sda_oe_n_o),
  .track_hold_o(track_hold_o), .adc_result_o(adc_result_o));

// File: tb/i2cac_master.sv
// i2cac_master.sv: behavioural bus master, 200 ns bit period.
// assumes a pulled-up wired-and data line fed back on sda_i.
`timescale 1ns/1ps
module i2cac_master (
  output reg scl_o,
  output reg sda_o,
  input wire sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // long lead-in lets a slave ack release before scl rises
  task st;
    begin
      sda_o = 1'b1;
      #150 scl_o = 1'b1;
      #100 sda_o = 1'b0;
      #100 scl_o = 1'b0;
    end
  endtask
  task sp;
    begin
      sda_o = 1'b0;
      #150 scl_o = 1'b1;
      #100 sda_o = 1'b1;
      #100;
    end
  endtask
  // long low phase: slave answers some cycles after the fall
  task bit_io(input b, output r);
    begin
      #40 sda_o = b;
      #90 scl_o = 1'b1;
      #70 r = sda_i;
      scl_o = 1'b0;
    end
  endtask
  task wr(input [7:0] d, output ack);
    reg r;
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
    end
  endtask
  task rd(input last, output [7:0] d);
    reg r;
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(1'b1, r);
        d[i] = r;
      end
      bit_io(last, r);
    end
  endtask
endmodule // i2cac_master

// File: tb/testbench.sv
// testbench.sv: directed scenarios for the converter front end.
// assumes the comparator is modelled from dac_code_o against VIN.
`timescale 1ns/1ps
module testbench;
  localparam [7:0] VIN = 8'h6b;
  reg core_clk_i = 1'b0;
  reg srst_i = 1'b1;
  integer err_total = 0;
  integer n_checks = 0;
  integer cyc = 0;
  wire scl_w, m_sda, sda_o, sda_oe_n_o, dac_enable_o, analog_output_pin_hiz_o;
  wire osc_enable_o, track_hold_o;
  wire [7:0] ctrl_o, dac_code_o, adc_result_o;
  wire [1:0] chan_sel_o, input_mode_o;
  wire sda_w = m_sda & (sda_oe_n_o | sda_o);
  wire cmp_w = (VIN >= dac_code_o);
  i2cac_master u_i2cac_master (.scl_o(scl_w), .sda_o(m_sda),
    .sda_i(sda_w));
  i2cac_top #(.FIXED_ADDR(4'h5), .SAR_STEP_CYC(8'd6)) u_i2cac_top (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl_w),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .addr_strap_bit0_i(1'b1), .addr_strap_bit1_i(1'b0),
    .addr_strap_bit2_i(1'b1), .cmp_i(cmp_w), .ctrl_o(ctrl_o),
    .chan_sel_o(chan_sel_o), .input_mode_o(input_mode_o),
    .dac_code_o(dac_code_o), .dac_enable_o(dac_enable_o),
    .analog_output_pin_hiz_o(analog_output_pin_hiz_o), .osc_enable_o(osc_enable_o),
    .track_hold_o(track_hold_o), .adc_result_o(adc_result_o));
  always #12.5 core_clk_i = ~core_clk_i;
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  always @(posedge core_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      give_verdict;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task settle;
    repeat (10) @(posedge core_clk_i);
  endtask
  task t_bad_addr;
    reg a;
    begin
      u_i2cac_master.st();
      u_i2cac_master.wr(8'h58, a);
      chk({7'h0, a}, 8'h00);
      u_i2cac_master.wr(8'hff, a);
      chk({7'h0, a}, 8'h00);
      u_i2cac_master.st();
      u_i2cac_master.wr(8'h4a, a);
      chk({7'h0, a}, 8'h00);
      u_i2cac_master.sp();
      chk(ctrl_o, 8'h00);
    end
  endtask
  task t_write;
    reg a;
    begin
      u_i2cac_master.st();
      u_i2cac_master.wr(8'h5a, a);
      chk({7'h0, a}, 8'h01);
      u_i2cac_master.wr(8'h40, a);
      settle;
      chk(ctrl_o, 8'h40);
      chk({6'h0, dac_enable_o, analog_output_pin_hiz_o}, 8'h02);
      chk({7'h0, osc_enable_o}, 8'h01);
      u_i2cac_master.wr(8'ha5, a);
      settle;
      chk(dac_code_o, 8'ha5);
      u_i2cac_master.wr(8'h3c, a);
      settle;
      chk(dac_code_o, 8'h3c);
      u_i2cac_master.sp();
    end
  endtask
  task t_read(input [7:0] first, input integer n, input [7:0] cexp);
    reg a;
    reg [7:0] d;
    integer i;
    begin
      u_i2cac_master.st();
      u_i2cac_master.wr(8'h5b, a);
      chk({7'h0, a}, 8'h01);
      for (i = 0; i < n; i = i + 1) begin
        u_i2cac_master.rd(i == n - 1, d);
        chk(d, (i == 0) ? first : VIN);
      end
      u_i2cac_master.sp();
      settle;
      chk(adc_result_o, VIN);
      chk(ctrl_o, cexp);
    end
  endtask
  task t_modes;
    reg a;
    integer m;
    begin
      for (m = 0; m < 4; m = m + 1) begin
        u_i2cac_master.st();
        u_i2cac_master.wr(8'h5a, a);
        u_i2cac_master.wr({2'b01, m[1:0], 4'h3}, a);
        settle;
        chk({6'h0, input_mode_o}, {6'h0, m[1:0]});
        chk({6'h0, chan_sel_o}, (m == 0) ? 8'h03 :
          (m == 3) ? 8'h01 : 8'h02);
      end
      u_i2cac_master.st();
      u_i2cac_master.wr(8'h5a, a);
      u_i2cac_master.wr(8'h77, a);
      settle;
      chk({6'h0, chan_sel_o}, 8'h01);
      t_read(VIN, 2, 8'h75);
    end
  endtask
  initial begin
    repeat (20) @(posedge core_clk_i);
    #2 srst_i = 1'b0;
    repeat (6) @(posedge core_clk_i);
    chk(ctrl_o, 8'h00);
    chk(adc_result_o, 8'h80);
    chk({4'h0, analog_output_pin_hiz_o, dac_enable_o, osc_enable_o, sda_oe_n_o},
      8'h09);
    $display("reset test done");
    t_bad_addr;
    $display("address test done");
    t_write;
    $display("write test done");
    t_read(8'h80, 1, 8'h40);
    $display("read test done");
    t_modes;
    $display("mode test done");
    give_verdict;
  end
endmodule // testbench
